// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the timer and interrupt transfer instruction unit.
// Assumes: Instructions and the accumulator pair are reached through the AXI4-Lite test port.
// Notes: A scoreboard of control nibbles, counts and reloads predicts every register view.
`timescale 1ns/1ns

module tb;
    import tirt_pkg::*;

    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ext_irq_pin_a = 1'b0;
    logic ext_irq_pin_b = 1'b0;
    logic [TMR_N-1:0] tmr_tick = '0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, skip_pending;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [TMR_N-1:0] tmr_underflow_flag;
    int error_cnt = 0;
    int tests_run = 0;
    logic [3:0] ctl [0:CTL_N-1];
    logic [7:0] cnt [0:TMR_N-1];
    logic [7:0] rld [0:TMR_N-1];
    logic [31:0] rd_val;
    logic [1:0] resp;
    logic [7:0] byte_v;
    logic [3:0] nib_v, b_v;

    always #4 clk_sys = ~clk_sys;

    tirt_unit tirt_unit_inst (.clk_sys(clk_sys), .srst(srst), .ext_irq_pin_a(ext_irq_pin_a),
        .ext_irq_pin_b(ext_irq_pin_b), .tmr_tick(tmr_tick), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tmr_underflow_flag(tmr_underflow_flag), .skip_pending(skip_pending));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctl_view();
        return {16'h0000, ctl[3], ctl[2], ctl[1], ctl[0]};
    endfunction

    function automatic logic [31:0] tctl_view();
        return {12'h000, ctl[8], ctl[7], ctl[6], ctl[5], ctl[4]};
    endfunction

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Both channels are offered together and each is released on its own handshake edge.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk_sys);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        r = bresp;
        bready <= 1'b0;
        // One idle edge, so a following call never lowers and raises bready in one time step.
        @(posedge clk_sys);
        if (n == 100)
        begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk_sys);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
        if (n == 100)
        begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic exec(input logic [OP_W-1:0] op);
        axi_wr(ADDR_INSTR, {22'h0, op}, resp);
    endtask

    task automatic set_ab(input logic [7:0] ab);
        axi_wr(ADDR_ACCB, {24'h0, ab}, resp);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd_val, resp);
        chk(rd_val, exp);
    endtask

    // A skipped control write must leave the first enable nibble as it was.
    task automatic follow_up(input logic exp_skip);
        logic [3:0] v;
        v = 4'($urandom);
        set_ab({4'h0, v});
        exec(OP_CTL_WR[0 +: OP_W]);
        if (!exp_skip)
            ctl[0] = v;
        rd_chk(ADDR_CTL_VIEW, ctl_view());
        axi_rd(ADDR_STATUS, rd_val, resp);
        chk({31'h0, rd_val[0]}, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < CTL_N; i++)
            ctl[i] = 4'h0;
        for (int i = 0; i < TMR_N; i++)
        begin
            cnt[i] = 8'h00;
            rld[i] = 8'h00;
        end
        void'($urandom(32'h97c2_7bc7));
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(ADDR_STATUS, 32'h0000_0000);
        rd_chk(ADDR_COUNT_VIEW, 32'h0000_0000);
        axi_rd(8'h1C, rd_val, resp);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk(rd_val, 32'h0000_0000);
        axi_wr(8'h1C, 32'h0000_00FF, resp);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("test reset_and_map done");

        for (int i = 0; i < CTL_N; i++)
        begin
            nib_v = 4'($urandom);
            b_v = 4'($urandom);
            set_ab({b_v, nib_v});
            exec(OP_CTL_WR[i*OP_W +: OP_W]);
            ctl[i] = nib_v;
            rd_chk(ADDR_CTL_VIEW, ctl_view());
            rd_chk(ADDR_TCTL_VIEW, tctl_view());
            set_ab({b_v, ~nib_v});
            exec(OP_CTL_RD[i*OP_W +: OP_W]);
            rd_chk(ADDR_ACCB, {24'h0, b_v, nib_v});
        end
        $display("test control_transfers done");

        for (int t = 0; t < TMR_N; t++)
        begin
            byte_v = (t == 0) ? 8'hFF : ((t == 3) ? 8'h01 : 8'($urandom));
            set_ab(byte_v);
            exec(OP_TMR_WR[t*OP_W +: OP_W]);
            cnt[t] = byte_v;
            rld[t] = byte_v;
            rd_chk(ADDR_COUNT_VIEW, {cnt[3], cnt[2], cnt[1], cnt[0]});
            rd_chk(ADDR_RELOAD_VIEW, {rld[3], rld[2], rld[1], rld[0]});
            set_ab(~byte_v);
            exec(OP_TMR_RD[t*OP_W +: OP_W]);
            rd_chk(ADDR_ACCB, {24'h0, byte_v});
        end
        for (int t = 0; t < TMR_N; t += 2)
        begin
            byte_v = 8'($urandom);
            set_ab(byte_v);
            exec(OP_RLD_WR[t*OP_W +: OP_W]);
            rld[t] = byte_v;
            rd_chk(ADDR_COUNT_VIEW, {cnt[3], cnt[2], cnt[1], cnt[0]});
            rd_chk(ADDR_RELOAD_VIEW, {rld[3], rld[2], rld[1], rld[0]});
        end
        $display("test timer_transfers done");

        for (int k = 0; k < 8; k++)
        begin
            nib_v = {1'($urandom), k[1], 2'($urandom)};
            set_ab({4'h0, nib_v});
            exec(OP_CTL_WR[(CTL_IRQ_A + k[0])*OP_W +: OP_W]);
            ctl[CTL_IRQ_A + k[0]] = nib_v;
            if (k[0])
                ext_irq_pin_b <= k[2];
            else
                ext_irq_pin_a <= k[2];
            // The pins pass a two-stage synchroniser before a test can see them.
            repeat (4) @(posedge clk_sys);
            exec(k[0] ? OP_SKIP_PIN_B : OP_SKIP_PIN_A);
            axi_rd(ADDR_STATUS, rd_val, resp);
            chk({31'h0, rd_val[0]}, {31'h0, k[2] == k[1]});
            chk({31'h0, skip_pending}, {31'h0, k[2] == k[1]});
            chk({30'h0, rd_val[6:5]}, {30'h0, ext_irq_pin_b, ext_irq_pin_a});
            follow_up(k[2] == k[1]);
        end
        $display("test pin_skips done");

        for (int t = 0; t < TMR_N; t++)
        begin
            set_ab(8'h00);
            exec(OP_TMR_WR[t*OP_W +: OP_W]);
            tmr_tick[t] <= 1'b1;
            @(posedge clk_sys);
            tmr_tick[t] <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk({28'h0, tmr_underflow_flag}, 32'h1 << t);
            exec(OP_FLAG_SKIP[t*OP_W +: OP_W]);
            axi_rd(ADDR_STATUS, rd_val, resp);
            chk({27'h0, rd_val[4:0]}, 32'h0000_0001);
            follow_up(1'b1);
            exec(OP_FLAG_SKIP[t*OP_W +: OP_W]);
            axi_rd(ADDR_STATUS, rd_val, resp);
            chk({27'h0, rd_val[4:0]}, 32'h0000_0000);
            rd_chk(ADDR_INSTR, {22'h0, OP_FLAG_SKIP[t*OP_W +: OP_W]});
            follow_up(1'b0);
        end
        $display("test flag_skips done");
        final_report();
    end
endmodule

// ---- verilog/tirt_pkg.sv ----
// Purpose: Shared constants for the timer and interrupt transfer instruction unit.
// Assumes: 10-bit instruction words, 4-bit accumulator and second register.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package tirt_pkg;
    localparam int OP_W = 10;
    localparam int NIB_W = 4;
    localparam int TMR_N = 4;
    localparam int CTL_N = 9;
    // Control register slots: irq enable a/b, ext irq ctrl a/b, timer ctrl 1,2,3,4,6.
    localparam int CTL_IRQ_A = 2;
    localparam int CTL_IRQ_B = 3;
    localparam int LEVEL_SEL_BIT = 2;
    localparam logic [OP_W-1:0] OP_SKIP_PIN_A = 10'h03A;
    localparam logic [OP_W-1:0] OP_SKIP_PIN_B = 10'h03B;
    localparam logic [CTL_N*OP_W-1:0] OP_CTL_RD = {10'h250, 10'h24E, 10'h24D, 10'h24C, 10'h24B,
                                                   10'h254, 10'h253, 10'h055, 10'h054};
    localparam logic [CTL_N*OP_W-1:0] OP_CTL_WR = {10'h213, 10'h211, 10'h210, 10'h20F, 10'h20E,
                                                   10'h218, 10'h217, 10'h03E, 10'h03F};
    localparam logic [TMR_N*OP_W-1:0] OP_TMR_RD = {10'h273, 10'h272, 10'h271, 10'h270};
    localparam logic [TMR_N*OP_W-1:0] OP_TMR_WR = {10'h233, 10'h232, 10'h231, 10'h230};
    localparam logic [TMR_N*OP_W-1:0] OP_RLD_WR = {10'h3FF, 10'h23B, 10'h3FF, 10'h23F};
    localparam logic [TMR_N-1:0] RLD_ONLY_EN = 4'h5;
    localparam logic [TMR_N*OP_W-1:0] OP_FLAG_SKIP = {10'h283, 10'h282, 10'h281, 10'h280};
    // Bus map.
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_ACCB = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CTL_VIEW = 8'h0C;
    localparam logic [7:0] ADDR_TCTL_VIEW = 8'h10;
    localparam logic [7:0] ADDR_COUNT_VIEW = 8'h14;
    localparam logic [7:0] ADDR_RELOAD_VIEW = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Values after reset.
    localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [OP_W-1:0] RST_OP = 10'h000;
endpackage

// ---- verilog/tirt_unit.sv ----
// Purpose: Executes the timer, interrupt-control and flag-test instructions of a 4-bit core.
// Assumes: Software issues instructions, one at a time, through the instruction register.
// Notes: Timer counting is reduced to a decrement on each tick pulse with reload on underflow.
`timescale 1ns/1ns

module tirt_unit
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk_sys, // System clock, 125 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic ext_irq_pin_a, // First external interrupt pin, asynchronous.
    input wire logic ext_irq_pin_b, // Second external interrupt pin, asynchronous.
    input wire logic [tirt_pkg::TMR_N-1:0] tmr_tick, // Count pulse per timer, same clock.
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic [tirt_pkg::TMR_N-1:0] tmr_underflow_flag, // Underflow flags a..d.
    output logic skip_pending // Next issued instruction will be suppressed.
);
    import tirt_pkg::*;

    // The decode compares byte addresses up to the reload view, so the field must hold them.
    if (ADDR_W < 5 || ADDR_W > 8)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic pin_a_meta_reg;
    logic pin_a_reg;
    logic pin_b_meta_reg;
    logic pin_b_reg;

    always_ff @(posedge clk_sys)
    begin
        pin_a_meta_reg <= ext_irq_pin_a;
        pin_a_reg <= pin_a_meta_reg;
        pin_b_meta_reg <= ext_irq_pin_b;
        pin_b_reg <= pin_b_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    logic aw_held_reg;
    logic [7:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_fire;
    logic wr_instr;
    logic wr_accb;
    logic wr_mapped;

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_instr = wr_fire && aw_addr_reg == ADDR_INSTR && w_strb_reg[1:0] == 2'h3;
    assign wr_accb = wr_fire && aw_addr_reg == ADDR_ACCB && w_strb_reg[0];
    assign wr_mapped = aw_addr_reg == ADDR_INSTR || aw_addr_reg == ADDR_ACCB;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_addr_reg <= RST_BYTE;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= 8'(s_axi_awaddr);
            end
            if (s_axi_wvalid && !w_held_reg)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction execution.

    logic [OP_W-1:0] op;
    logic [OP_W-1:0] last_op_reg;
    logic skip_reg;
    logic exec_en;
    logic [NIB_W-1:0] acc_reg;
    logic [NIB_W-1:0] b_reg;
    logic [NIB_W-1:0] ctl_reg [CTL_N];
    logic [7:0] cnt_reg [TMR_N];
    logic [7:0] rld_reg [TMR_N];
    logic [TMR_N-1:0] flag_reg;
    logic [CTL_N-1:0] ctl_rd_hit;
    logic [CTL_N-1:0] ctl_wr_hit;
    logic [TMR_N-1:0] tmr_rd_hit;
    logic [TMR_N-1:0] tmr_wr_hit;
    logic [TMR_N-1:0] rld_wr_hit;
    logic [TMR_N-1:0] flag_hit;
    logic pin_a_hit;
    logic pin_b_hit;
    logic skip_cond;
    logic [NIB_W-1:0] acc_next;
    logic [NIB_W-1:0] b_next;

    assign op = w_data_reg[OP_W-1:0];
    // A suppressed instruction still uses up its cycle, so it consumes the skip.
    assign exec_en = wr_instr && !skip_reg;
    assign pin_a_hit = ctl_reg[CTL_IRQ_A][LEVEL_SEL_BIT] == pin_a_reg;
    assign pin_b_hit = ctl_reg[CTL_IRQ_B][LEVEL_SEL_BIT] == pin_b_reg;
    assign skip_cond = (op == OP_SKIP_PIN_A && pin_a_hit) || (op == OP_SKIP_PIN_B && pin_b_hit)
                       || |(flag_hit & flag_reg);

    genvar gi;
    generate
        for (gi = 0; gi < CTL_N; gi++)
        begin : g_ctl
            assign ctl_rd_hit[gi] = exec_en && op == OP_CTL_RD[gi*OP_W +: OP_W];
            assign ctl_wr_hit[gi] = exec_en && op == OP_CTL_WR[gi*OP_W +: OP_W];
            always_ff @(posedge clk_sys)
            begin
                if (srst)
                    ctl_reg[gi] <= RST_NIB;
                else if (ctl_wr_hit[gi])
                    ctl_reg[gi] <= acc_reg;
            end
        end
        for (gi = 0; gi < TMR_N; gi++)
        begin : g_tmr
            logic underflow;
            assign tmr_rd_hit[gi] = exec_en && op == OP_TMR_RD[gi*OP_W +: OP_W];
            assign tmr_wr_hit[gi] = exec_en && op == OP_TMR_WR[gi*OP_W +: OP_W];
            assign rld_wr_hit[gi] = exec_en && RLD_ONLY_EN[gi] && op == OP_RLD_WR[gi*OP_W +: OP_W];
            assign flag_hit[gi] = exec_en && op == OP_FLAG_SKIP[gi*OP_W +: OP_W];
            assign underflow = tmr_tick[gi] && cnt_reg[gi] == RST_BYTE && !tmr_wr_hit[gi];
            always_ff @(posedge clk_sys)
            begin
                if (srst)
                begin
                    cnt_reg[gi] <= RST_BYTE;
                    rld_reg[gi] <= RST_BYTE;
                    flag_reg[gi] <= 1'b0;
                end
                else
                begin
                    if (tmr_wr_hit[gi] || rld_wr_hit[gi])
                        rld_reg[gi] <= {b_reg, acc_reg};
                    if (tmr_wr_hit[gi])
                        cnt_reg[gi] <= {b_reg, acc_reg};
                    else if (underflow)
                        cnt_reg[gi] <= rld_reg[gi];
                    else if (tmr_tick[gi])
                        cnt_reg[gi] <= cnt_reg[gi] - 8'h01;
                    // A new underflow in the clearing cycle wins over the clear.
                    if (underflow)
                        flag_reg[gi] <= 1'b1;
                    else if (flag_hit[gi])
                        flag_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_comb
    begin
        acc_next = acc_reg;
        b_next = b_reg;
        if (wr_accb)
        begin
            acc_next = w_data_reg[3:0];
            b_next = w_data_reg[7:4];
        end
        for (int i = 0; i < CTL_N; i++)
        begin
            if (ctl_rd_hit[i])
                acc_next = ctl_reg[i];
        end
        for (int i = 0; i < TMR_N; i++)
        begin
            if (tmr_rd_hit[i])
            begin
                b_next = cnt_reg[i][7:4];
                acc_next = cnt_reg[i][3:0];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            acc_reg <= RST_NIB;
            b_reg <= RST_NIB;
            skip_reg <= 1'b0;
            last_op_reg <= RST_OP;
        end
        else
        begin
            acc_reg <= acc_next;
            b_reg <= b_next;
            if (wr_instr)
            begin
                skip_reg <= exec_en && skip_cond;
                last_op_reg <= op;
            end
        end
    end

    assign skip_pending = skip_reg;
    assign tmr_underflow_flag = flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rd_fire;
    logic [7:0] rd_addr;
    logic [31:0] rd_word;
    logic rd_mapped;

    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign rd_addr = 8'(s_axi_araddr);
    assign rd_mapped = rd_addr <= ADDR_RELOAD_VIEW && rd_addr[1:0] == 2'h0;
    assign rd_word = rd_addr == ADDR_INSTR ? {22'h00_0000, last_op_reg} :
                     rd_addr == ADDR_ACCB ? {24'h00_0000, b_reg, acc_reg} :
                     rd_addr == ADDR_STATUS ? {25'h000_0000, pin_b_reg, pin_a_reg, flag_reg, skip_reg} :
                     rd_addr == ADDR_CTL_VIEW ? {16'h0000, ctl_reg[3], ctl_reg[2], ctl_reg[1], ctl_reg[0]} :
                     rd_addr == ADDR_TCTL_VIEW ?
                         {12'h000, ctl_reg[8], ctl_reg[7], ctl_reg[6], ctl_reg[5], ctl_reg[4]} :
                     rd_addr == ADDR_COUNT_VIEW ? {cnt_reg[3], cnt_reg[2], cnt_reg[1], cnt_reg[0]} :
                     rd_addr == ADDR_RELOAD_VIEW ? {rld_reg[3], rld_reg[2], rld_reg[1], rld_reg[0]} :
                     32'h0000_0000;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mapped ? rd_word : 32'h0000_0000;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    pin_a_skip_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_SKIP_PIN_A |=> skip_reg == $past(pin_a_hit))
        else $error("pin a test gave the wrong skip");
    pin_b_skip_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_SKIP_PIN_B |=> skip_reg == $past(ctl_reg[CTL_IRQ_B][LEVEL_SEL_BIT] == pin_b_reg))
        else $error("pin b test gave the wrong skip");
    ctl_load_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_CTL_WR[0 +: OP_W] |=> ctl_reg[0] == $past(acc_reg))
        else $error("control load lost the accumulator");
    ctl_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_CTL_RD[4*OP_W +: OP_W] |=> acc_reg == $past(ctl_reg[4]))
        else $error("control read did not reach the accumulator");
    tmr_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_TMR_RD[0 +: OP_W] |=> {b_reg, acc_reg} == $past(cnt_reg[0]))
        else $error("timer read split the count wrongly");
    tmr_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_TMR_WR[OP_W +: OP_W] |=>
        cnt_reg[1] == $past({b_reg, acc_reg}) && rld_reg[1] == $past({b_reg, acc_reg}))
        else $error("timer write missed count or reload");
    reload_only_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_RLD_WR[0 +: OP_W] && !tmr_tick[0] |=>
        cnt_reg[0] == $past(cnt_reg[0]) && rld_reg[0] == $past({b_reg, acc_reg}))
        else $error("reload-only write disturbed the count");
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_FLAG_SKIP[0 +: OP_W] && flag_reg[0] && !tmr_tick[0] |=> skip_reg && !flag_reg[0])
        else $error("flag test did not skip and clear");
    skip_once_a: assert property (@(posedge clk_sys) disable iff (srst)
        skip_reg && wr_instr |=> !skip_reg && $stable(acc_reg) ##0 $stable(ctl_reg[0]))
        else $error("suppressed instruction took effect");
    ext_ctl_load_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_CTL_WR[CTL_IRQ_B*OP_W +: OP_W] |=> ctl_reg[CTL_IRQ_B] == $past(acc_reg))
        else $error("external control load lost the accumulator");
    tmr_read_d_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_TMR_RD[3*OP_W +: OP_W] |=> {b_reg, acc_reg} == $past(cnt_reg[3]))
        else $error("timer d read split the count wrongly");
    tmr_write_d_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_TMR_WR[3*OP_W +: OP_W] |=>
        cnt_reg[3] == $past({b_reg, acc_reg}) && rld_reg[3] == $past({b_reg, acc_reg}))
        else $error("timer d write missed count or reload");
    reload_only_c_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_RLD_WR[2*OP_W +: OP_W] && !tmr_tick[2] |=>
        cnt_reg[2] == $past(cnt_reg[2]) && rld_reg[2] == $past({b_reg, acc_reg}))
        else $error("reload-only write disturbed timer c");
    flag_clear_b_a: assert property (@(posedge clk_sys) disable iff (srst)
        exec_en && op == OP_FLAG_SKIP[OP_W +: OP_W] && flag_reg[1] && !tmr_tick[1] |=>
        skip_reg && !flag_reg[1])
        else $error("timer b flag test did not skip and clear");
endmodule
